// ==== tb/tdd_datapath_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdd_datapath_sva (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [2:0] event_enable_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic digital_out_pin_o,
  input wire logic [2:0] warn_level_o,
  input wire logic [2:0] warn_event_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Filtered output may lag a disable, so only the never-enabled case is strict
  logic seen_on_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) seen_on_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 8'h07 && reg_wdata_i[15]) seen_on_q <= 1'b1;
  end
  sequence s_thr_wr;
    reg_wr_i && reg_addr_i inside {[8'h03:8'h06]} ##1 $stable(reg_addr_i);
  endsequence
  sequence s_a_rise;
    $rose(warn_level_o[0]) && $past(event_enable_i[0]);
  endsequence
  a_dec_upper_zero: assert property (reg_addr_i == 8'h10 |=> reg_rdata_o[15:8] == 8'h00) else $error("dec upper");
  a_filt_resv_zero: assert property (reg_addr_i inside {8'h07, 8'h08, 8'h09} |=> !reg_rdata_o[13]) else $error("resv");
  a_thr_readback: assert property (s_thr_wr |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback");
  a_bin_forced_low: assert property (!seen_on_q |-> !digital_out_pin_o) else $error("bin off");
  a_event_on_rise: assert property (warn_event_o[0] |-> $rose(warn_level_o[0])) else $error("event rise");
  a_event_enabled: assert property (warn_event_o[0] |-> $past(event_enable_i[0])) else $error("event mask");
  a_event_fires: assert property (s_a_rise |-> warn_event_o[0]) else $error("event lost");
  a_event_single: assert property (warn_event_o[0] |=> !warn_event_o[0]) else $error("event long");
endmodule // tdd_datapath_sva
bind tdd_datapath tdd_datapath_sva u_tdd_datapath_sva (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .event_enable_i, .reg_rdata_o, .digital_out_pin_o, .warn_level_o, .warn_event_o);
`default_nettype wire

// ==== tb/tdd_datapath_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tdd_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module tdd_datapath_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] adc_sample_i, reg_addr_i;
  logic adc_valid_i, reg_wr_i, digital_out_pin_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, rv;
  logic [2:0] event_enable_i, warn_level_o, warn_event_o;
  int err_total = 0;
  int compares = 0;
  int n;
  logic [15:0] rst_t [8] = '{`TDD_RST_CTRL, `TDD_RST_BINARY_THRESHOLD_LEVELS, `TDD_RST_WA_THR, `TDD_RST_WB_THR, `TDD_RST_WC_THR,
    `TDD_RST_BIN_FILT, `TDD_RST_WA_FILT, `TDD_RST_WB_FILT};
  logic [15:0] msk_t [8] = '{`TDD_CTRL_WMASK, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, `TDD_FILT_WMASK,
    `TDD_FILT_WMASK, `TDD_FILT_WMASK};
  logic [7:0] wv_t [4] = '{8'hFF, 8'h00, 8'h70, 8'hFF};
  logic [2:0] wl_t [4] = '{3'h1, 3'h4, 3'h2, 3'h1};
  logic [2:0] we_t [4] = '{3'h1, 3'h4, 3'h2, 3'h0};
  logic [2:0] ev;
  logic [3:0] hi_t = 4'h5;
  logic [3:0] mid_t = 4'hB;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  tdd_datapath u_tdd_datapath (.ref_clk_i, .rst_n_i, .adc_sample_i, .adc_valid_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .event_enable_i, .reg_rdata_o, .digital_out_pin_o, .warn_level_o, .warn_event_o);
  tdd_host_model host (.ref_clk_i, .rdata_i(reg_rdata_o), .adc_sample_o(adc_sample_i), .adc_valid_o(adc_valid_i),
    .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .event_enable_o(event_enable_i));
  task automatic complete_run;
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] v, input logic e);
    logic p;
    p = digital_out_pin_o;
    host.smp(v);
    // The pin moves two edges after the capturing edge; look once before and once after
    @(negedge ref_clk_i);
    `CHK("dout_early", p, digital_out_pin_o)
    @(negedge ref_clk_i);
    `CHK("dout", e, digital_out_pin_o)
  endtask
  // Six units: a 4 to 5 unit burst survives a short drop only when counting down
  task automatic dbn(input logic [15:0] cfg, input logic fast);
    host.wr(`TDD_OFS_BIN_FILT, cfg);
    host.smp(8'h00);
    repeat (5000) @(negedge ref_clk_i);
    host.smp(8'hFF);
    repeat (3950) @(negedge ref_clk_i);
    `CHK("glitch_held", 1'b0, digital_out_pin_o)
    host.smp(8'h00);
    repeat (100) @(negedge ref_clk_i);
    host.smp(8'hFF);
    for (n = 0; n < 6000 && digital_out_pin_o !== 1'b1; n++) @(negedge ref_clk_i);
    if (n == 6000) begin
      err_total++;
      complete_run();
    end
    `CHK("settle_speed", fast, n < 2500)
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    host.wr(`TDD_OFS_DEC_SAMPLE, 16'hFFFF);
    host.rd(`TDD_OFS_DEC_SAMPLE, rv);
    `CHK("dec_ro", 16'h0000, rv)
    send(8'hFF, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host.rd(8'(i + 2), rv);
      `CHK("reset_val", rst_t[i], rv)
      host.wr(8'(i + 2), 16'hFFFF);
      host.rd(8'(i + 2), rv);
      `CHK("wr_mask", msk_t[i], rv)
      host.wr(8'(i + 2), rst_t[i]);
    end
    for (int r = 0; r < 4; r++) begin
      host.wr(`TDD_OFS_CTRL, 16'h3611 | 16'(r << 1));
      for (int k = 0; k < (1 << r); k++) host.smp(8'(k * 32));
      host.rd(`TDD_OFS_DEC_SAMPLE, rv);
      `CHK("decimated", 16'(((1 << r) - 1) * 16), rv)
    end
    host.wr(`TDD_OFS_CTRL, `TDD_RST_CTRL);
    host.wr(`TDD_OFS_BIN_FILT, 16'h8000);
    send(8'hAB, 1'b1);
    send(8'hAA, 1'b1);
    send(8'h5B, 1'b1);
    send(8'h5A, 1'b0);
    send(8'hAA, 1'b0);
    for (int s = 0; s < 4; s++) begin
      host.wr(`TDD_OFS_CTRL, `TDD_RST_CTRL | 16'(s << 6));
      send(8'hB0, hi_t[s]);
      send(8'h80, mid_t[s]);
    end
    host.wr(`TDD_OFS_CTRL, `TDD_RST_CTRL);
    dbn(16'h8006, 1'b0);
    dbn(16'hC006, 1'b1);
    host.wr(`TDD_OFS_WA_FILT, 16'h8000);
    host.wr(`TDD_OFS_WB_FILT, 16'h8000);
    host.smp(8'h00);
    for (int i = 0; i < 4; i++) begin
      // All three events enabled, then masked, so each channel's edge is seen once
      host.en((i < 3) ? 3'h7 : 3'h0);
      host.smp(wv_t[i]);
      n = 0;
      ev = 3'h0;
      repeat (5) begin
        @(negedge ref_clk_i);
        n += warn_event_o[0];
        ev |= warn_event_o;
      end
      `CHK("warn_level", wl_t[i], warn_level_o)
      `CHK("warn_event", 32'(i == 0), n)
      `CHK("warn_events", we_t[i], ev)
    end
    host.wr(`TDD_OFS_WA_FILT, 16'h0000);
    repeat (4) @(negedge ref_clk_i);
    `CHK("warn_a_off", 1'b0, warn_level_o[0])
    complete_run();
  end
endmodule // tdd_datapath_tb
`default_nettype wire

// ==== tb/tdd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdd_host_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] rdata_i,
  output var logic [7:0] adc_sample_o,
  output var logic adc_valid_o,
  output var logic reg_wr_o,
  output var logic [7:0] reg_addr_o,
  output var logic [15:0] reg_wdata_o,
  output var logic [2:0] event_enable_o
);
  initial begin
    adc_sample_o = 8'h00;
    adc_valid_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    event_enable_o = 3'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    // Stale data is inverted so a late capture cannot match by luck
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask
  task automatic smp(input logic [7:0] v);
    @(negedge ref_clk_i);
    adc_sample_o = v;
    adc_valid_o = 1'b1;
    @(negedge ref_clk_i);
    adc_valid_o = 1'b0;
    adc_sample_o = ~v;
  endtask
  task automatic en(input logic [2:0] e);
    @(negedge ref_clk_i);
    event_enable_o = e;
  endtask
endmodule // tdd_host_model
`default_nettype wire

// ==== verilog/tdd_datapath.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tdd_defs.vh"

module tdd_datapath (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [7:0] adc_sample_i,
  input wire adc_valid_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [2:0] event_enable_i,
  output reg [15:0] reg_rdata_o,
  output reg digital_out_pin_o,
  output reg [2:0] warn_level_o,
  output reg [2:0] warn_event_o
);

  localparam [31:0] UNIT_CYCLES_W = `TDD_UNIT_CYCLES;
  localparam [9:0] UNIT_LAST = UNIT_CYCLES_W[9:0] - 10'h001;

  reg [15:0] ctrl_q;
  reg [15:0] thr_q [0:3];
  reg [15:0] filt_q [0:2];
  reg [7:0] decimated_sample_reg;
  reg [10:0] acc_q;
  reg [2:0] phase_q;
  reg dec_valid_q;
  reg [3:0] cmp_q;
  reg [9:0] unit_cnt_q;
  reg unit_tick_q;
  reg [2:0] warn_prev_q;

  wire decimation_on = ctrl_q[`TDD_DEC_ON_BIT];
  wire [1:0] decimation_ratio_sel = ctrl_q[`TDD_DEC_SEL_LSB +: 2];
  wire decimating = decimation_on && (decimation_ratio_sel != 2'h0);
  wire [10:0] acc_sum = acc_q + {3'h0, adc_sample_i};
  wire binary_path_on = filt_q[0][`TDD_PATH_ON_BIT];
  wire [2:0] deb_out;
  wire [2:0] warn_now;
  integer k;

  // Last phase index (samples per output minus one) for codes 0..3
  function [2:0] ratio_last;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: ratio_last = 3'h1;
        2'h2: ratio_last = 3'h3;
        2'h3: ratio_last = 3'h7;
        default: ratio_last = 3'h0;
      endcase
    end
  endfunction

  function [7:0] avg;
    input [10:0] sum;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: avg = sum[8:1];
        2'h2: avg = sum[9:2];
        2'h3: avg = sum[10:3];
        default: avg = sum[7:0];
      endcase
    end
  endfunction

  function cmp_next;
    input [1:0] style;
    input [7:0] v;
    input [15:0] thr;
    input prev;
    reg [7:0] upper;
    reg [7:0] lower;
    begin
      upper = thr[`TDD_UPPER_LSB +: 8];
      lower = thr[`TDD_LOWER_LSB +: 8];
      case (style)
        `TDD_STYLE_HYST: begin
          if (v > upper) begin
            cmp_next = 1'b1;
          end else if (v <= lower) begin
            cmp_next = 1'b0;
          end else begin
            cmp_next = prev;
          end
        end
        `TDD_STYLE_MID: cmp_next = (v < upper) && (v > lower);
        `TDD_STYLE_GT: cmp_next = (v > upper);
        `TDD_STYLE_LE: cmp_next = (v <= upper);
        default: cmp_next = prev;
      endcase
    end
  endfunction

  // Register writes; reserved bits are masked so they read zero
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `TDD_RST_CTRL;
      thr_q[0] <= `TDD_RST_BINARY_THRESHOLD_LEVELS;
      thr_q[1] <= `TDD_RST_WA_THR;
      thr_q[2] <= `TDD_RST_WB_THR;
      thr_q[3] <= `TDD_RST_WC_THR;
      filt_q[0] <= `TDD_RST_BIN_FILT;
      filt_q[1] <= `TDD_RST_WA_FILT;
      filt_q[2] <= `TDD_RST_WB_FILT;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `TDD_OFS_CTRL: ctrl_q <= reg_wdata_i & `TDD_CTRL_WMASK;
        `TDD_OFS_BINARY_THRESHOLD_LEVELS: thr_q[0] <= reg_wdata_i;
        `TDD_OFS_WA_THR: thr_q[1] <= reg_wdata_i;
        `TDD_OFS_WB_THR: thr_q[2] <= reg_wdata_i;
        `TDD_OFS_WC_THR: thr_q[3] <= reg_wdata_i;
        `TDD_OFS_BIN_FILT: filt_q[0] <= reg_wdata_i & `TDD_FILT_WMASK;
        `TDD_OFS_WA_FILT: filt_q[1] <= reg_wdata_i & `TDD_FILT_WMASK;
        `TDD_OFS_WB_FILT: filt_q[2] <= reg_wdata_i & `TDD_FILT_WMASK;
        default: ;
      endcase
    end
  end

  // Registered read data, one cycle after the address; unmapped reads zero
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_addr_i)
        `TDD_OFS_CTRL: reg_rdata_o <= ctrl_q;
        `TDD_OFS_BINARY_THRESHOLD_LEVELS: reg_rdata_o <= thr_q[0];
        `TDD_OFS_WA_THR: reg_rdata_o <= thr_q[1];
        `TDD_OFS_WB_THR: reg_rdata_o <= thr_q[2];
        `TDD_OFS_WC_THR: reg_rdata_o <= thr_q[3];
        `TDD_OFS_BIN_FILT: reg_rdata_o <= filt_q[0];
        `TDD_OFS_WA_FILT: reg_rdata_o <= filt_q[1];
        `TDD_OFS_WB_FILT: reg_rdata_o <= filt_q[2];
        `TDD_OFS_DEC_SAMPLE: reg_rdata_o <= {8'h00, decimated_sample_reg};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Decimator: averages 2, 4 or 8 samples so the comparators see a smoothed value
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 11'h000;
      phase_q <= 3'h0;
      decimated_sample_reg <= 8'h00;
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= 1'b0;
      if (adc_valid_i) begin
        if (!decimating) begin
          decimated_sample_reg <= adc_sample_i;
          dec_valid_q <= 1'b1;
          acc_q <= 11'h000;
          phase_q <= 3'h0;
        end else if (phase_q >= ratio_last(decimation_ratio_sel)) begin
          decimated_sample_reg <= avg(acc_sum, decimation_ratio_sel);
          dec_valid_q <= 1'b1;
          acc_q <= 11'h000;
          phase_q <= 3'h0;
        end else begin
          acc_q <= acc_sum;
          phase_q <= phase_q + 3'h1;
        end
      end
    end
  end

  // Comparators act on each new sample; a disabled path is held low
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_q <= 4'h0;
    end else begin
      if (!binary_path_on) begin
        cmp_q[0] <= 1'b0;
      end else if (dec_valid_q) begin
        cmp_q[0] <= cmp_next(ctrl_q[`TDD_BIN_STYLE_LSB +: 2], decimated_sample_reg, thr_q[0], cmp_q[0]);
      end
      for (k = 1; k < 3; k = k + 1) begin
        if (!filt_q[k][`TDD_PATH_ON_BIT]) begin
          cmp_q[k] <= 1'b0;
        end else if (dec_valid_q) begin
          cmp_q[k] <= cmp_next(ctrl_q[`TDD_WA_STYLE_LSB + 2 * (k - 1) +: 2], decimated_sample_reg, thr_q[k], cmp_q[k]);
        end
      end
      if (dec_valid_q) begin
        cmp_q[3] <= cmp_next(ctrl_q[`TDD_WC_STYLE_LSB +: 2], decimated_sample_reg, thr_q[3], cmp_q[3]);
      end
    end
  end

  // 20 us time base for all debounce counters
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_cnt_q <= 10'h000;
      unit_tick_q <= 1'b0;
    end else if (unit_cnt_q == UNIT_LAST) begin
      unit_cnt_q <= 10'h000;
      unit_tick_q <= 1'b1;
    end else begin
      unit_cnt_q <= unit_cnt_q + 10'h001;
      unit_tick_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_deb
      tdd_debounce u_deb (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .unit_tick_i(unit_tick_q),
        .level_i(cmp_q[g]),
        .bidir_i(filt_q[g][`TDD_BIDIR_BIT]),
        .length_i(filt_q[g][`TDD_LEN_LSB +: 13]),
        .level_o(deb_out[g])
      );
    end
  endgenerate

  // Warning C has no debounce filter; its comparator is used directly
  assign warn_now = {cmp_q[3], deb_out[2:1]};

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      digital_out_pin_o <= 1'b0;
      warn_level_o <= 3'h0;
      warn_prev_q <= 3'h0;
      warn_event_o <= 3'h0;
    end else begin
      digital_out_pin_o <= deb_out[0];
      warn_level_o <= warn_now;
      warn_prev_q <= warn_now;
      warn_event_o <= warn_now & ~warn_prev_q & event_enable_i;
    end
  end

endmodule // tdd_datapath

`default_nettype wire

// ==== verilog/tdd_debounce.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tdd_defs.vh"

module tdd_debounce (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire unit_tick_i,
  input wire level_i,
  input wire bidir_i,
  input wire [12:0] length_i,
  output wire level_o
);

  reg state_q;
  reg [12:0] count_q;

  // Zero length bypasses the counter entirely
  assign level_o = (length_i == 13'h0000) ? level_i : state_q;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= 1'b0;
      count_q <= 13'h0000;
    end else if (length_i == 13'h0000) begin
      state_q <= level_i;
      count_q <= 13'h0000;
    end else if (level_i != state_q) begin
      if (unit_tick_i) begin
        // Output changes once the new level has counted the full length; in bidir mode a short drop only counts down
        if (count_q + 13'h0001 >= length_i) begin
          state_q <= level_i;
          count_q <= 13'h0000;
        end else begin
          count_q <= count_q + 13'h0001;
        end
      end
    end else if (bidir_i) begin
      if (unit_tick_i && count_q != 13'h0000) begin
        count_q <= count_q - 13'h0001;
      end
    end else begin
      count_q <= 13'h0000;
    end
  end

endmodule // tdd_debounce

`default_nettype wire

// ==== verilog/tdd_defs.vh ====
`ifndef TDD_DEFS_VH
`define TDD_DEFS_VH

// Register offsets, word addressed
`define TDD_OFS_CTRL 8'h02
`define TDD_OFS_BINARY_THRESHOLD_LEVELS 8'h03
`define TDD_OFS_WA_THR 8'h04
`define TDD_OFS_WB_THR 8'h05
`define TDD_OFS_WC_THR 8'h06
`define TDD_OFS_BIN_FILT 8'h07
`define TDD_OFS_WA_FILT 8'h08
`define TDD_OFS_WB_FILT 8'h09
`define TDD_OFS_DEC_SAMPLE 8'h10

// Reset values
`define TDD_RST_CTRL 16'h3610
`define TDD_RST_BINARY_THRESHOLD_LEVELS 16'h5AAA
`define TDD_RST_WA_THR 16'hCCCC
`define TDD_RST_WB_THR 16'h5A88
`define TDD_RST_WC_THR 16'h2D2D
`define TDD_RST_BIN_FILT 16'h0096
`define TDD_RST_WA_FILT 16'h80FA
`define TDD_RST_WB_FILT 16'h80FA

// Control register fields
`define TDD_CTRL_WMASK 16'h7FFF
`define TDD_DEC_ON_BIT 0
`define TDD_DEC_SEL_LSB 1
`define TDD_BIN_STYLE_LSB 6
`define TDD_WA_STYLE_LSB 8
`define TDD_WB_STYLE_LSB 10
`define TDD_WC_STYLE_LSB 12

// Threshold register fields
`define TDD_UPPER_LSB 0
`define TDD_LOWER_LSB 8

// Debounce config fields
`define TDD_FILT_WMASK 16'hDFFF
`define TDD_PATH_ON_BIT 15
`define TDD_BIDIR_BIT 14
`define TDD_LEN_LSB 0

// Comparator styles
`define TDD_STYLE_HYST 2'h0
`define TDD_STYLE_MID 2'h1
`define TDD_STYLE_GT 2'h2
`define TDD_STYLE_LE 2'h3

// Debounce unit time
`define TDD_CLK_MHZ 40
`define TDD_UNIT_US 20
`define TDD_UNIT_CYCLES (`TDD_UNIT_US * `TDD_CLK_MHZ)

`endif
